// [core/cifb_consts.svh]
/*
 * Register offsets, field positions and reset values of the CPU
 * interrupt flag bank. Assumes inclusion by the flag bank and its bench.
 */
`ifndef CIFB_CONSTS_SVH
`define CIFB_CONSTS_SVH

// Printed offsets are not all multiples of four: they are word indices
`define CIFB_IDX_CRYPTO 8'h98
`define CIFB_IDX_RADIO 8'h9B
`define CIFB_IDX_TPD 8'hC0

// Reset values
`define CIFB_RST_FLAGS 8'h00

// Paired flag positions
`define CIFB_PAIR_HI 1
`define CIFB_PAIR_LO 0

// Timer, port and DMA register fields
`define CIFB_SLEEP_BIT 7
`define CIFB_RSVD_BIT 6
`define CIFB_PORT0_BIT 5
`define CIFB_T4_BIT 4
`define CIFB_T3_BIT 3
`define CIFB_T2_BIT 2
`define CIFB_T1_BIT 1
`define CIFB_DMA_BIT 0

`endif

// [core/cifb_pkg.sv]
/*
 * Types shared by the CPU interrupt flag bank.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package cifb_pkg;
  // Which CPU flag register an address selects
  typedef enum logic [3:0] {
    CIFB_SEL_NONE = 4'b0001,
    CIFB_SEL_CRYPTO = 4'b0010,
    CIFB_SEL_RADIO = 4'b0100,
    CIFB_SEL_TPD = 4'b1000
  } cifb_sel_t;
endpackage : cifb_pkg

`default_nettype wire

// [core/cifb_flag_bank.sv]
/*
 * CPU interrupt flag bank: crypto pair, radio pair and the timer, port 0,
 * sleep timer and DMA flags, reached over APB.
 * Assumes one 250 MHz clock, sources giving one-cycle or level set
 * requests, and the CPU pulsing a vector acknowledge per timer flag.
 */
// Summary of operation
// - Crypto event sets both crypto flags
// - Radio event sets both radio flags
// - Either pair flag alone requests interrupt
// - Crypto flags independent RW, reset zero
// - Radio flags independent RW, reset zero
// - Timer flags set, cleared on vectoring
// - Sleep timer flag at bit seven
// - Port zero flag at bit five
// - DMA done flag at bit zero
// - Unused upper bits zero, no effect
// - Flags set regardless of enable
// - Clearing rechecks enabled asserted flags
`include "cifb_consts.svh"
`default_nettype none

module cifb_flag_bank
  import cifb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral set requests
  input wire logic crypto_irq_i,
  input wire logic radio_irq_i,
  input wire logic sleep_timer_irq_i,
  input wire logic port_zero_irq_i,
  input wire logic [3:0] timer_irq_i,
  input wire logic dma_done_irq_i,
  // CPU vectoring acknowledge, timer 1..4
  input wire logic [3:0] timer_vector_ack_i,
  // Enables, held in the enable registers elsewhere
  input wire logic [7:0] irq_enable_i,
  // Module flag clear strobe and remaining module flags
  input wire logic module_flag_clr_i,
  input wire logic module_flags_pending_i,
  // Requests to the CPU
  output logic crypto_req_o,
  output logic radio_req_o,
  output logic [7:0] tpd_req_o,
  output logic [7:0] flags_o
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic cifb_sel_t decode(input logic [11:0] addr);
    cifb_sel_t sel;
    sel = CIFB_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[11:2] == {2'h0, `CIFB_IDX_CRYPTO}) sel = CIFB_SEL_CRYPTO;
      if (addr[11:2] == {2'h0, `CIFB_IDX_RADIO}) sel = CIFB_SEL_RADIO;
      if (addr[11:2] == {2'h0, `CIFB_IDX_TPD}) sel = CIFB_SEL_TPD;
    end
    return sel;
  endfunction

  cifb_sel_t sel;
  logic access;
  logic wr;
  logic [7:0] wbyte;

  assign sel = decode(paddr_i);
  assign access = psel_i && penable_i;
  // Only lane 0 carries flag bits, so only its strobe matters
  assign wr = access && pwrite_i && pstrb_i[0] && (sel != CIFB_SEL_NONE);
  assign wbyte = pwdata_i[7:0];
  assign pready_o = 1'b1;
  assign pslverr_o = access && (sel == CIFB_SEL_NONE);

  // ****************************************
  // Crypto and radio pairs
  // ****************************************
  logic [1:0] crypto_q;
  logic [1:0] radio_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crypto_q <= 2'h0;
    end else begin
      if (wr && sel == CIFB_SEL_CRYPTO) begin
        crypto_q <= wbyte[1:0];
      end
      // Set after write so a clash keeps the event
      if (crypto_irq_i) begin
        crypto_q <= 2'h3;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      radio_q <= 2'h0;
    end else begin
      if (wr && sel == CIFB_SEL_RADIO) begin
        radio_q <= wbyte[1:0];
      end
      if (radio_irq_i) begin
        radio_q <= 2'h3;
      end
    end
  end

  assign crypto_req_o = |crypto_q;
  assign radio_req_o = |radio_q;

  // ****************************************
  // Timer, port 0, sleep timer, DMA flags
  // ****************************************
  logic [7:0] tpd_q;
  logic [7:0] tpd_set;
  logic [7:0] tpd_hwclr;
  logic [7:0] tpd_d;

  always_comb begin
    tpd_set = 8'h00;
    tpd_set[`CIFB_SLEEP_BIT] = sleep_timer_irq_i;
    tpd_set[`CIFB_PORT0_BIT] = port_zero_irq_i;
    tpd_set[`CIFB_T4_BIT:`CIFB_T1_BIT] = timer_irq_i;
    tpd_set[`CIFB_DMA_BIT] = dma_done_irq_i;
    tpd_hwclr = 8'h00;
    tpd_hwclr[`CIFB_T4_BIT:`CIFB_T1_BIT] = timer_vector_ack_i;
    tpd_d = tpd_q & ~tpd_hwclr;
    if (wr && sel == CIFB_SEL_TPD) begin
      // Bit 6 is stored as written; software is expected to keep it 0
      tpd_d = wbyte;
    end
    tpd_d = tpd_d | tpd_set;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tpd_q <= `CIFB_RST_FLAGS;
    end else begin
      tpd_q <= tpd_d;
    end
  end

  // Reserved bit 6 requests too, hence the continuous reentry hazard
  assign tpd_req_o = tpd_q & irq_enable_i;

  // ****************************************
  // Module flag recheck
  // ****************************************
  logic recheck_q;

  // Reasserts both radio flags on flags_o for one cycle when other module flags still stand
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      recheck_q <= 1'b0;
    end else begin
      recheck_q <= module_flag_clr_i && module_flags_pending_i;
    end
  end

  logic [1:0] radio_recheck;
  assign radio_recheck = recheck_q ? 2'h3 : 2'h0;

  assign flags_o = {tpd_q[7:2], radio_q | radio_recheck};

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (sel)
        CIFB_SEL_CRYPTO: prdata_o <= {30'h0, crypto_q};
        CIFB_SEL_RADIO: prdata_o <= {30'h0, radio_q};
        CIFB_SEL_TPD: prdata_o <= {24'h0, tpd_q};
        CIFB_SEL_NONE: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_crypto_pair: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    crypto_irq_i |=> crypto_q == 2'h3)
    else $error("crypto pair not set");

  chk_radio_pair: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    radio_irq_i |=> radio_q == 2'h3)
    else $error("radio pair not set");

  chk_single_req: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_CRYPTO && wbyte[1:0] == 2'h2 && !crypto_irq_i)
      |=> crypto_req_o)
    else $error("single crypto flag gave no request");

  chk_radio_req: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_RADIO && wbyte[1:0] == 2'h1 && !radio_irq_i)
      |=> radio_req_o)
    else $error("single radio flag gave no request");

  chk_crypto_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_CRYPTO && !crypto_irq_i)
      |=> crypto_q == $past(wbyte[1:0]))
    else $error("crypto write lost");

  chk_crypto_hold: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!crypto_irq_i && !(wr && sel == CIFB_SEL_CRYPTO))
      |=> crypto_q == $past(crypto_q))
    else $error("crypto pair changed unprompted");

  chk_radio_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_RADIO && !radio_irq_i)
      |=> radio_q == $past(wbyte[1:0]))
    else $error("radio write lost");

  chk_radio_hold: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!radio_irq_i && !(wr && sel == CIFB_SEL_RADIO))
      |=> radio_q == $past(radio_q))
    else $error("radio pair changed unprompted");

  chk_timer_vector: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_vector_ack_i[0] && !timer_irq_i[0] && !wr) |=> !tpd_q[`CIFB_T1_BIT])
    else $error("timer 1 flag not cleared on vectoring");

  chk_timer2_vector: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_vector_ack_i[1] && !timer_irq_i[1] && !wr) |=> !tpd_q[`CIFB_T2_BIT])
    else $error("timer 2 flag not cleared on vectoring");

  chk_timer3_vector: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_vector_ack_i[2] && !timer_irq_i[2] && !wr) |=> !tpd_q[`CIFB_T3_BIT])
    else $error("timer 3 flag not cleared on vectoring");

  chk_timer4_vector: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_vector_ack_i[3] && !timer_irq_i[3] && !wr) |=> !tpd_q[`CIFB_T4_BIT])
    else $error("timer 4 flag not cleared on vectoring");

  chk_timer_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_irq_i != 4'h0) |=> (tpd_q[`CIFB_T4_BIT:`CIFB_T1_BIT]
      & $past(timer_irq_i)) == $past(timer_irq_i))
    else $error("timer flag not set");

  chk_sleep_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    sleep_timer_irq_i |=> tpd_q[`CIFB_SLEEP_BIT])
    else $error("sleep timer flag not set");

  chk_port0_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    port_zero_irq_i |=> tpd_q[`CIFB_PORT0_BIT])
    else $error("port 0 flag not set");

  chk_dma_set: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    dma_done_irq_i |=> tpd_q[`CIFB_DMA_BIT])
    else $error("dma flag not set");

  chk_tpd_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_TPD && tpd_set == 8'h00)
      |=> tpd_q == $past(wbyte))
    else $error("flag register write lost");

  chk_upper_zero: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (psel_i && !penable_i && sel == CIFB_SEL_RADIO)
      |=> prdata_o[31:2] == 30'h0)
    else $error("radio upper bits not zero");

  chk_crypto_upper: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (psel_i && !penable_i && sel == CIFB_SEL_CRYPTO)
      |=> prdata_o[31:2] == 30'h0)
    else $error("crypto upper bits not zero");

  chk_set_wins: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr && sel == CIFB_SEL_TPD && wbyte == 8'h00 && dma_done_irq_i)
      |=> tpd_q[`CIFB_DMA_BIT])
    else $error("clear beat hardware set");

  chk_vector_loses: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (timer_irq_i[0] && timer_vector_ack_i[0])
      |=> tpd_q[`CIFB_T1_BIT])
    else $error("vectoring beat timer set");

  chk_recheck: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (module_flag_clr_i && module_flags_pending_i)
      |=> flags_o[1:0] == 2'h3)
    else $error("recheck did not reassert");

  chk_no_recheck: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (module_flag_clr_i && !module_flags_pending_i)
      |=> flags_o[1:0] == radio_q)
    else $error("recheck fired with nothing pending");

endmodule : cifb_flag_bank

`default_nettype wire

// [dv/cifb_irq_src_model.sv]
/* Peripheral set sources and CPU vector acknowledge for the flag bank.
   Assumes the bench calls fire() from one thread at a time. */
`default_nettype none
module cifb_irq_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Crypto, radio, sleep, port0, timer[4], dma, vector ack[4]
  output logic [12:0] ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev_o = '0;
  // Lines are levels, so holding longer only repeats the set, or the clear on the vector ack lines
  task automatic fire(input logic [12:0] v, input int n);
    @(posedge clk_sys_i);
    ev_o <= v;
    repeat (n) @(posedge clk_sys_i);
    ev_o <= '0;
  endtask
endmodule // cifb_irq_src_model
`default_nettype wire

// [dv/cpu_irq_flag_bank_tb.sv]
/* Bench for the CPU interrupt flag bank: APB tasks and flag scenarios.
   Assumes design, package, header and source model are compiled. */
`include "cifb_consts.svh"
`default_nettype none
module cpu_irq_flag_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CRY = {2'h0, `CIFB_IDX_CRYPTO, 2'h0};
  localparam logic [11:0] A_RAD = {2'h0, `CIFB_IDX_RADIO, 2'h0};
  localparam logic [11:0] A_TPD = {2'h0, `CIFB_IDX_TPD, 2'h0};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b0, pend = 1'b0;
  logic [11:0] padr = '0;
  logic [31:0] pwd = '0, rd, prdata;
  logic [7:0] en = '0, tpd_req, flags;
  logic [12:0] ev;
  logic pready, perr, err, creq, rreq;
  int fails = 0;
  int samples_checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  cifb_irq_src_model u_cifb_irq_src_model (.clk_sys_i(clk_sys_i), .ev_o(ev));
  cifb_flag_bank u_cifb_flag_bank (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .crypto_irq_i(ev[0]), .radio_irq_i(ev[1]), .sleep_timer_irq_i(ev[2]),
    .port_zero_irq_i(ev[3]), .timer_irq_i(ev[7:4]), .dma_done_irq_i(ev[8]),
    .timer_vector_ack_i(ev[12:9]), .irq_enable_i(en),
    .module_flag_clr_i(clr), .module_flags_pending_i(pend),
    .crypto_req_o(creq), .radio_req_o(rreq), .tpd_req_o(tpd_req),
    .flags_o(flags));
  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // Request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, d};
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk(nm, {24'h0, e}, rd);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdchk("crypto", A_CRY, 8'h00);
    rdchk("radio", A_RAD, 8'h00);
    rdchk("tpd", A_TPD, 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
    u_cifb_irq_src_model.fire(13'h001, 1);
    rdchk("crypto pair", A_CRY, 8'h03);
    u_cifb_irq_src_model.fire(13'h002, 1);
    rdchk("radio pair", A_RAD, 8'h03);
    apb(1'b1, A_CRY, 8'h02);
    rdchk("crypto hi", A_CRY, 8'h02);
    chk("crypto req", 32'h1, {31'h0, creq});
    apb(1'b1, A_RAD, 8'h01);
    rdchk("radio lo", A_RAD, 8'h01);
    chk("radio req", 32'h1, {31'h0, rreq});
    apb(1'b1, A_RAD, 8'h00);
    apb(1'b1, A_CRY, 8'h00);
    @(negedge clk_sys_i);
    chk("reqs idle", 32'h0, {30'h0, creq, rreq});
    // Set and clear meet in one cycle
    // Set pulse lands on the write's access edge only
    fork
      begin
        @(posedge clk_sys_i);
        u_cifb_irq_src_model.fire(13'h001, 1);
      end
      apb(1'b1, A_CRY, 8'h00);
    join
    rdchk("set beats clear", A_CRY, 8'h03);
    // Reset in mid-run clears a set pair
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdchk("crypto reset", A_CRY, 8'h00);
    $display("test pairs done");
    u_cifb_irq_src_model.fire(13'h1FC, 1);
    rdchk("tpd set", A_TPD, 8'hBF);
    chk("req masked", 32'h0, {24'h0, tpd_req});
    u_cifb_irq_src_model.fire(13'h1E00, 1);
    rdchk("tpd vector", A_TPD, 8'hA1);
    en <= 8'hFF;
    @(negedge clk_sys_i);
    chk("tpd req", 32'hA1, {24'h0, tpd_req});
    chk("flags upper", 32'h28, {26'h0, flags[7:2]});
    apb(1'b1, A_TPD, 8'h00);
    rdchk("tpd clr", A_TPD, 8'h00);
    fork
      begin
        @(posedge clk_sys_i);
        u_cifb_irq_src_model.fire(13'h100, 1);
      end
      apb(1'b1, A_TPD, 8'h00);
    join
    rdchk("dma beats clear", A_TPD, 8'h01);
    u_cifb_irq_src_model.fire(13'h210, 1);
    rdchk("set beats vector", A_TPD, 8'h03);
    clr <= 1'b1;
    pend <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    @(negedge clk_sys_i);
    chk("recheck", 32'h3, {30'h0, flags[1:0]});
    @(negedge clk_sys_i);
    chk("recheck end", 32'h0, {30'h0, flags[1:0]});
    @(posedge clk_sys_i);
    clr <= 1'b1;
    pend <= 1'b0;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    @(negedge clk_sys_i);
    chk("no recheck", 32'h0, {30'h0, flags[1:0]});
    $display("test tpd done");
    report_and_stop();
  end
endmodule // cpu_irq_flag_bank_tb
`default_nettype wire
